// ==== bench/pm_model.sv ====
// Program memory model driven from the block's memory port.
// Assumes the block samples read data while its read request is up.
`timescale 1ns/1ps
`default_nettype none
module pm_model (
  input wire logic i_clk,
  input wire pspace_pkg::pm_t i_pm,
  output logic [23:0] o_rdata
);
  import pspace_pkg::*;
  logic [23:0] last_reg = 24'h000000;
  // ==========================================
  // Word pattern derived from the byte address
  function automatic logic [23:0] pat(input logic [23:0] a);
    return {a[8:1] ^ 8'h3C, a[16:1] ^ 16'h9A5F};
  endfunction : pat
  // Idle bus toggles so a stale word is never read as valid
  assign o_rdata = i_pm.rd ? pat(i_pm.addr) : ~last_reg;
  always_ff @(posedge i_clk) begin
    last_reg <= o_rdata;
  end
endmodule : pm_model
`default_nettype wire

// ==== bench/program_space_data_access_tb.sv ====
// Self-checking bench for table reads and program-view reads.
// Assumes the program memory model answers in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module program_space_data_access_tb;
  import pspace_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  req_t i_req = '0;
  logic [1:0] i_reg_addr = 2'h0;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [23:0] i_pm_rdata;
  logic [15:0] o_reg_rdata;
  pm_t o_pm;
  resp_t o_resp;
  logic o_stall;
  resp_t r;
  logic [23:0] a;
  logic [23:0] p;
  logic [15:0] ea;
  int err_total = 0;
  int checked = 0;
  int lat;
  int stl;
  logic [9:0] vp [4] = '{10'h202, 10'h302, 10'h3FF, 10'h2FF};
  logic [2:0] vm [4] = '{3'b100, 3'b000, 3'b011, 3'b010};
  logic [3:0] ve [4] = '{4'h1, 4'h2, 4'h2, 4'h0};
  logic [9:0] np [4] = '{10'h202, 10'h000, 10'h105, 10'h202};
  op_t nop [4] = '{DATA_READ_OP, DATA_READ_OP, DATA_READ_OP, DATA_WRITE_OP};
  logic [15:0] nea [4] = '{16'h7FFE, 16'h8000, 16'hC000, 16'h8000};
  logic [3:0] nf [4] = '{4'b0100, 4'b1000, 4'b0010, 4'b0010};

  program_space_data_access program_space_data_access_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_req(i_req), .i_pm_rdata(i_pm_rdata),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_pm(o_pm), .o_resp(o_resp),
    .o_stall(o_stall));
  pm_model pm_model_inst (.i_clk(i_clk), .i_pm(o_pm), .o_rdata(i_pm_rdata));

  // ==========================================
  // Clock and helpers
  always #5 i_clk = ~i_clk;

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic reg_wr(input logic [1:0] ad, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= ad;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask : reg_wr

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [1:0] ad, input logic [15:0] exp);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= ad;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk({8'h00, o_reg_rdata}, {8'h00, exp});
  endtask : reg_rd

  // One request; counts cycles to done and cycles stalled
  task automatic req(input op_t op, input logic bm, sm, rpt, edg, input logic [15:0] e);
    @(posedge i_clk);
    i_req <= '{1'b1, op, bm, sm, rpt, edg, e, 16'h1234};
    @(posedge i_clk);
    i_req.valid <= 1'b0;
    stl = 0;
    for (lat = 1; lat <= 10; lat++) begin
      #1;
      stl += int'(o_stall === 1'b1);
      if (o_resp.done === 1'b1) break;
      @(posedge i_clk);
    end
    if (lat > 10) begin
      err_total++;
      report_and_stop();
    end
    r = o_resp;
  endtask : req

  // Expected table read result
  function automatic logic [15:0] fmt(input logic hi, bm, b0, input logic [23:0] w);
    if (hi) return bm ? {8'h00, b0 ? 8'h00 : w[23:16]} : {8'h00, w[23:16]};
    return bm ? {8'h00, b0 ? w[15:8] : w[7:0]} : w[15:0];
  endfunction : fmt

  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    reg_rd(2'h0, 16'h0000);
    reg_rd(2'h1, 16'h0001);
    reg_rd(2'h2, 16'h0001);
    reg_wr(2'h3, 16'hFFFF);
    reg_rd(2'h3, 16'h0000);
    reg_wr(2'h0, 16'h0012);
    // Every table read form, both byte selects
    for (int k = 0; k < 8; k++) begin
      ea = 16'hC6A4 | 16'(k[0]);
      req(k[2] ? TABLE_READ_HIGH_OP : TABLE_READ_LOW_OP, k[1], 1'b0, 1'b0, 1'b0, ea);
      a = {8'h12, ea[15:1], 1'b0};
      chk(o_pm.addr, a);
      chk({8'h00, r.rdata}, {8'h00, fmt(k[2], k[1], k[0], pm_model_inst.pat(a))});
      chk({19'h0, o_pm.cfg, 4'(lat)}, 24'h000002);
    end
    // Configuration space: reads go through, writes refused
    reg_wr(2'h0, 16'h0092);
    req(TABLE_READ_LOW_OP, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0010);
    chk({23'h0, o_pm.cfg}, 24'h000001);
    req(TABLE_WRITE_LOW_OP, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0010);
    chk({12'h0, 4'(stl), r.trap, r.near, r.ext, r.refused, 4'(lat)}, 24'h000011);
    // Program-view reads with each stall case
    for (int k = 0; k < 4; k++) begin
      reg_wr(2'h1, {6'h00, vp[k]});
      ea = k[0] ? 16'hFFFE : 16'h800A;
      req(DATA_READ_OP, 1'b0, vm[k][2], vm[k][1], vm[k][0], ea);
      a = {1'b0, vp[k][7:0], ea[14:1], vp[k][8]};
      p = pm_model_inst.pat(a);
      chk(o_pm.addr, a);
      chk({8'h00, r.rdata}, vp[k][8] ? {16'h0, p[23:16]} : {8'h00, p[15:0]});
      chk({12'h0, 4'(stl), r.trap, r.near, r.ext, r.refused, 4'(lat)},
          {12'h0, 4'(ve[k] + 4'h1), 4'h0, 4'(ve[k] + 4'h2)});
    end
    // Accesses that never fetch
    for (int k = 0; k < 4; k++) begin
      reg_wr(2'h1, {6'h00, np[k]});
      req(nop[k], 1'b0, 1'b0, 1'b0, 1'b0, nea[k]);
      chk({12'h0, 4'(stl), r.trap, r.near, r.ext, r.refused, 4'(lat)},
          {12'h0, 4'h0, nf[k], 4'h1});
    end
    // Byte read through the view: odd select gives the upper byte of the low word
    reg_wr(2'h1, 16'h0202);
    ea = 16'h8005;
    req(DATA_READ_OP, 1'b1, 1'b1, 1'b0, 1'b0, ea);
    a = {1'b0, 8'h02, ea[14:1], 1'b0};
    p = pm_model_inst.pat(a);
    chk({8'h00, r.rdata}, {16'h0, p[15:8]});
    chk({16'h0, 4'(stl), 4'(lat)}, 24'h000023);
    // User-space table write reaches memory with one byte lane
    reg_wr(2'h0, 16'h0012);
    req(TABLE_WRITE_HIGH_OP, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0021);
    chk({o_pm.wr, o_pm.cfg, o_pm.byte_en, 4'(lat), o_pm.wdata}, {4'b1010, 4'h1, 16'h1234});
    chk(o_pm.addr, 24'h120020);
    chk({20'h0, r.trap, r.near, r.ext, r.refused}, 24'h000000);
    // Write page zero traps an upper write; a reset in mid-run restores both pages
    reg_wr(2'h2, 16'h0000);
    req(DATA_WRITE_OP, 1'b0, 1'b0, 1'b0, 1'b0, 16'h9000);
    chk({12'h0, 4'(stl), r.trap, r.near, r.ext, r.refused, 4'(lat)}, 24'h000081);
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    reg_rd(2'h1, 16'h0001);
    reg_rd(2'h2, 16'h0001);
    req(DATA_WRITE_OP, 1'b0, 1'b0, 1'b0, 1'b0, 16'h9000);
    chk({12'h0, 4'(stl), r.trap, r.near, r.ext, r.refused, 4'(lat)}, 24'h000021);
    report_and_stop();
  end
endmodule : program_space_data_access_tb
`default_nettype wire

// ==== pkg/pspace_pkg.sv ====
// Shared types and constants for the program-space data access block.
// Assumes a single core clock domain and a core that holds requests off while stalled.
package pspace_pkg;

  // ==========================================
  // Register map of the plain register port
  localparam logic [1:0] TABLE_PAGE_OFS = 2'h0;
  localparam logic [1:0] READ_PAGE_OFS = 2'h1;
  localparam logic [1:0] WRITE_PAGE_OFS = 2'h2;
  localparam logic [1:0] STATUS_OFS = 2'h3;

  // ==========================================
  // Reset values and field positions
  localparam logic [7:0] TABLE_PAGE_RST = 8'h00;
  localparam logic [9:0] READ_PAGE_RST = 10'h001;
  localparam logic [8:0] WRITE_PAGE_RST = 9'h001;
  localparam int TBL_CFG_BIT = 7;
  localparam int RPG_PROG_BIT = 9;
  localparam int RPG_HALF_BIT = 8;
  localparam int EA_UPPER_BIT = 15;

  // ==========================================
  // Extra stall cycles of a program-view access
  localparam logic [1:0] STALL_MOVE = 2'h1;
  localparam logic [1:0] STALL_OTHER = 2'h2;
  localparam logic [1:0] STALL_RPT_EDGE = 2'h2;
  localparam logic [1:0] STALL_RPT_MID = 2'h0;

  // ==========================================
  // Operation codes from the core
  typedef enum logic [2:0] {
    TABLE_READ_LOW_OP = 3'h0,
    TABLE_READ_HIGH_OP = 3'h1,
    TABLE_WRITE_LOW_OP = 3'h2,
    TABLE_WRITE_HIGH_OP = 3'h3,
    DATA_READ_OP = 3'h4,
    DATA_WRITE_OP = 3'h5
  } op_t;

  // Core request, valid for one cycle
  typedef struct packed {
    logic valid;
    op_t op;
    logic byte_mode;
    logic single_move;
    logic in_repeat;
    logic repeat_edge;
    logic [15:0] ea;
    logic [15:0] wdata;
  } req_t;

  // Program memory port
  typedef struct packed {
    logic rd;
    logic wr;
    logic cfg;
    logic [1:0] byte_en;
    logic [23:0] addr;
    logic [15:0] wdata;
  } pm_t;

  // Answer to the core
  typedef struct packed {
    logic done;
    logic trap;
    logic near;
    logic ext;
    logic refused;
    logic [15:0] rdata;
  } resp_t;

endpackage : pspace_pkg

// ==== rtl/program_space_data_access.sv ====
// Address generation and data formatting for core reads of program memory as data.
// Assumes the core issues one request at a time and only while o_stall is low;
// program memory read data follows the address combinationally.
// Behaviour
// R1: Table low word read returns P<15:0>
// R2: Table low byte read picks byte by select
// R3: Table high word read zeroes phantom byte
// R4: Table high byte read, phantom byte reads zero
// R5: Program address steps by two per word
// R6: Table page bit 7 selects configuration space
// R7: No table writes into configuration space
// R8: Program view needs EA MSb and page bit 9
// R9: View address is page low byte plus EA<14:0>
// R10: Read page bit 8 selects word half
// R11: 512 view pages, lower and upper halves
// R12: Upper data half maps onto one page
// R13: Upper pointer with page zero traps
// R14: Upper half at odd addresses, reads only
// R15: One extra cycle for moves, else two
// R16: In repeat, two extra only on edges
// R17: Table address is page appended to EA
// R18: Lower pointers ignore page registers
// R19: Stall exactly the extra cycles, then return; the block stalls one fetch cycle plus the extra cycles
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module program_space_data_access (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire pspace_pkg::req_t i_req,
  input wire logic [23:0] i_pm_rdata,
  input wire logic [1:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  output pspace_pkg::pm_t o_pm,
  output pspace_pkg::resp_t o_resp,
  output logic o_stall
);
  import pspace_pkg::*;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_FETCH = 1'b1
  } state_t;

  // ==========================================
  // Registers and request decode
  logic [7:0] table_page_reg;
  logic [9:0] read_page_reg;
  logic [8:0] write_page_reg;
  state_t state_reg;
  logic [1:0] cnt_reg;
  req_t cur_reg;
  logic is_table;
  logic is_table_wr;
  logic upper_ptr;
  logic view_rd;
  logic trap_now;
  logic [1:0] extra;

  assign is_table = (i_req.op == TABLE_READ_LOW_OP) || (i_req.op == TABLE_READ_HIGH_OP)
    || is_table_wr;
  assign is_table_wr = (i_req.op == TABLE_WRITE_LOW_OP) || (i_req.op == TABLE_WRITE_HIGH_OP);
  assign upper_ptr = !is_table && i_req.ea[EA_UPPER_BIT];
  // Page zero on an upper pointer is invalid [R13]
  assign trap_now = upper_ptr && ((i_req.op == DATA_READ_OP) ? (read_page_reg == 10'h000)
    : (write_page_reg == 9'h000));
  // Program view only for reads with page bit 9 set; data writes never reach program memory [R8] [R14]
  assign view_rd = upper_ptr && !trap_now && (i_req.op == DATA_READ_OP) && read_page_reg[RPG_PROG_BIT];

  // Extra cycles: moves one, others two; repeat body free except at its edges [R15] [R16]
  always_comb begin
    if (!is_table && i_req.in_repeat) begin
      extra = i_req.repeat_edge ? STALL_RPT_EDGE : STALL_RPT_MID;
    end else if (!is_table) begin
      extra = i_req.single_move ? STALL_MOVE : STALL_OTHER;
    end else begin
      extra = 2'h0;
    end
  end

  // ==========================================
  // Software-visible page registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      table_page_reg <= TABLE_PAGE_RST;
      read_page_reg <= READ_PAGE_RST;
      write_page_reg <= WRITE_PAGE_RST;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        TABLE_PAGE_OFS: table_page_reg <= i_reg_wdata[7:0];
        READ_PAGE_OFS: read_page_reg <= i_reg_wdata[9:0];
        WRITE_PAGE_OFS: write_page_reg <= i_reg_wdata[8:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; status shows block state
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        TABLE_PAGE_OFS: o_reg_rdata <= {8'h00, table_page_reg};
        READ_PAGE_OFS: o_reg_rdata <= {6'h00, read_page_reg};
        WRITE_PAGE_OFS: o_reg_rdata <= {7'h00, write_page_reg};
        default: o_reg_rdata <= {13'h0000, o_pm.cfg, o_pm.rd, state_reg == ST_FETCH};
      endcase
    end else begin
      o_reg_rdata <= 16'h0000;
    end
  end

  // ==========================================
  // Result formatting from a fetched 24-bit word
  function automatic logic [15:0] fmt(input logic [23:0] w, input logic hi, input logic bm, input logic bsel);
    logic [15:0] r;
    r = 16'h0000;
    if (!hi && !bm) begin
      r = w[15:0]; // [R1]
    end else if (!hi) begin
      r = {8'h00, bsel ? w[15:8] : w[7:0]}; // [R2]
    end else if (!bm) begin
      r = {8'h00, w[23:16]}; // Phantom byte forced low [R3]
    end else begin
      r = {8'h00, bsel ? 8'h00 : w[23:16]}; // [R4]
    end
    return r;
  endfunction : fmt

  // ==========================================
  // Sequencer: latch request, hold stall for one fetch cycle plus the extra cycles, then answer
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      cur_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (i_req.valid && ((is_table && !is_table_wr) || view_rd)) begin
            state_reg <= ST_FETCH;
            cnt_reg <= extra; // [R19]
            cur_reg <= i_req;
          end
        end
        ST_FETCH: begin
          if (cnt_reg == 2'h0) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 2'h1; // [R19]
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign o_stall = (state_reg == ST_FETCH); // [R19]

  // Program memory port, one word per two address steps
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pm <= '0;
    end else if (state_reg == ST_IDLE && i_req.valid) begin
      o_pm.wdata <= i_req.wdata;
      o_pm.byte_en <= i_req.byte_mode ? (i_req.ea[0] ? 2'b10 : 2'b01) : 2'b11;
      o_pm.rd <= (is_table && !is_table_wr) || view_rd;
      // Configuration writes are dropped [R7]
      o_pm.wr <= is_table_wr && !table_page_reg[TBL_CFG_BIT];
      if (is_table) begin
        o_pm.cfg <= table_page_reg[TBL_CFG_BIT]; // [R6]
        o_pm.addr <= {table_page_reg, i_req.ea[15:1], 1'b0}; // [R17] [R5]
      end else begin
        o_pm.cfg <= 1'b0;
        // Odd address for the upper half; one of 512 pages of 16K words [R9] [R10] [R11] [R12] [R14]
        o_pm.addr <= {1'b0, read_page_reg[7:0], i_req.ea[14:1], read_page_reg[RPG_HALF_BIT]};
      end
    end else if (state_reg == ST_IDLE) begin
      o_pm.rd <= 1'b0;
      o_pm.wr <= 1'b0;
    end else if (cnt_reg == 2'h0) begin
      o_pm.rd <= 1'b0;
    end
  end

  // Answer to the core, one cycle pulse
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_resp <= '0;
    end else begin
      o_resp <= '0;
      if (state_reg == ST_FETCH && cnt_reg == 2'h0) begin
        o_resp.done <= 1'b1;
        if (cur_reg.op == DATA_READ_OP) begin
          o_resp.rdata <= fmt(i_pm_rdata, read_page_reg[RPG_HALF_BIT], cur_reg.byte_mode, cur_reg.ea[0]);
        end else begin
          o_resp.rdata <= fmt(i_pm_rdata, cur_reg.op == TABLE_READ_HIGH_OP, cur_reg.byte_mode, cur_reg.ea[0]);
        end
      end else if (state_reg == ST_IDLE && i_req.valid && !((is_table && !is_table_wr) || view_rd)) begin
        o_resp.done <= 1'b1;
        o_resp.trap <= trap_now; // [R13]
        o_resp.near <= !is_table && !upper_ptr; // [R18]
        o_resp.ext <= upper_ptr && !trap_now;
        o_resp.refused <= is_table_wr && table_page_reg[TBL_CFG_BIT]; // [R7]
      end
    end
  end

  // ==========================================
  // Checks
  logic idle_req;
  logic view_req;
  assign idle_req = i_req.valid && state_reg == ST_IDLE;
  assign view_req = idle_req && view_rd;

  AST_VIEW_ADDR: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R9] [R10]
    view_req |=> o_pm.rd && o_pm.addr == {1'b0, $past(read_page_reg[7:0]), $past(i_req.ea[14:1]),
      $past(read_page_reg[8])}) else $error("program view address wrong");
  AST_TABLE_ADDR: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R17] [R6]
    idle_req && is_table |=> o_pm.addr[23:1] == {$past(table_page_reg), $past(i_req.ea[15:1])}
      && o_pm.cfg == $past(table_page_reg[7])) else $error("table address wrong");
  AST_TRAP: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R13]
    idle_req && i_req.op == DATA_READ_OP && i_req.ea[15] && read_page_reg == 10'h000
      |=> o_resp.trap && o_resp.done && !o_pm.rd) else $error("missing address trap");
  AST_NEAR: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R18]
    idle_req && !is_table && !i_req.ea[15] |=> o_resp.near && !o_pm.rd && !o_stall)
    else $error("near access not direct");
  AST_CFG_WRITE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R7]
    idle_req && is_table_wr && table_page_reg[7] |=> o_resp.refused && !o_pm.wr)
    else $error("configuration write not refused");
  AST_NO_VIEW_WRITE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R14] [R8]
    idle_req && i_req.op == DATA_WRITE_OP |=> !o_pm.wr && !o_pm.rd) else $error("view write reached memory");
  AST_STALL_MOVE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R15] [R19]
    view_req && !i_req.in_repeat && i_req.single_move |=> o_stall[*2] ##1 (o_resp.done && !o_stall))
    else $error("move stall not one extra cycle");
  AST_STALL_OTHER: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R15]
    view_req && !i_req.in_repeat && !i_req.single_move |=> o_stall[*3] ##1 o_resp.done)
    else $error("other stall not two extra cycles");
  AST_REPEAT: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R16]
    view_req && i_req.in_repeat && !i_req.repeat_edge |=> o_stall ##1 (o_resp.done && !o_stall))
    else $error("repeat body not single cycle");
  AST_PHANTOM: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R3] [R4]
    o_resp.done && $past(o_stall) && cur_reg.op == TABLE_READ_HIGH_OP |-> o_resp.rdata[15:8] == 8'h00)
    else $error("phantom byte not zero");
  AST_LOW_WORD: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R1]
    o_stall && cnt_reg == 2'h0 && cur_reg.op == TABLE_READ_LOW_OP && !cur_reg.byte_mode
      |=> o_resp.rdata == $past(i_pm_rdata[15:0])) else $error("low word read wrong");

  // Each table read form against the fetched word; the phantom byte never leaks
  AST_TABLE_BYTE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R2]
    o_stall && cnt_reg == 2'h0 && cur_reg.op == TABLE_READ_LOW_OP && cur_reg.byte_mode
      |=> o_resp.rdata == {8'h00, $past(cur_reg.ea[0]) ? $past(i_pm_rdata[15:8]) : $past(i_pm_rdata[7:0])})
    else $error("low byte read wrong");
  AST_HIGH_WORD: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R3]
    o_stall && cnt_reg == 2'h0 && cur_reg.op == TABLE_READ_HIGH_OP && !cur_reg.byte_mode
      |=> o_resp.rdata == {8'h00, $past(i_pm_rdata[23:16])}) else $error("high word read wrong");
  AST_HIGH_BYTE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R4]
    o_stall && cnt_reg == 2'h0 && cur_reg.op == TABLE_READ_HIGH_OP && cur_reg.byte_mode
      |=> o_resp.rdata == {8'h00, $past(cur_reg.ea[0]) ? 8'h00 : $past(i_pm_rdata[23:16])})
    else $error("high byte read wrong");

  // View data checked against the half held in the address; the block formats by read page bit 8 as it stands at the answer
  AST_VIEW_LOW: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R10]
    o_stall && cnt_reg == 2'h0 && cur_reg.op == DATA_READ_OP && !cur_reg.byte_mode && !o_pm.addr[0]
      |=> o_resp.rdata == $past(i_pm_rdata[15:0])) else $error("view lower word wrong");
  AST_VIEW_HIGH: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R10]
    o_stall && cnt_reg == 2'h0 && cur_reg.op == DATA_READ_OP && !cur_reg.byte_mode && o_pm.addr[0]
      |=> o_resp.rdata == {8'h00, $past(i_pm_rdata[23:16])}) else $error("view upper word wrong");

  // Address forming and space selection
  AST_WORD_STEP: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R5]
    idle_req && is_table |=> !o_pm.addr[0]) else $error("table address not word aligned");
  AST_VIEW_GATE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R8]
    idle_req && i_req.op == DATA_READ_OP && !(i_req.ea[EA_UPPER_BIT] && read_page_reg[RPG_PROG_BIT])
      |=> !o_pm.rd && !o_stall) else $error("program view without page bit 9");
  AST_VIEW_USER: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R12] [R14]
    view_req |=> !o_pm.cfg && !o_pm.addr[23] && !o_pm.wr) else $error("view left user space");
  AST_CFG_READ: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R6] [R7]
    idle_req && is_table && !is_table_wr && table_page_reg[TBL_CFG_BIT]
      |=> o_pm.rd && o_pm.cfg && !o_resp.refused) else $error("configuration read blocked");
  AST_NEAR_PLAIN: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R18]
    idle_req && !is_table && !i_req.ea[EA_UPPER_BIT]
      |=> !o_resp.trap && !o_resp.ext && !o_pm.wr) else $error("near access used a page");

  // Stall lengths; no pulse check spans two cycles, since requests may follow back to back
  AST_TABLE_FAST: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R19]
    idle_req && is_table && !is_table_wr |=> o_stall ##1 (o_resp.done && !o_stall)) else $error("table read stall wrong");
  AST_REPEAT_EDGE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R16]
    view_req && i_req.in_repeat && i_req.repeat_edge |=> o_stall[*3] ##1 (o_resp.done && !o_stall))
    else $error("repeat edge not two extra cycles");
  AST_RD_STALL: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R19]
    o_pm.rd == o_stall) else $error("fetch request and stall disagree");
  AST_DONE_IDLE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R19]
    o_resp.done |-> !o_stall) else $error("answer while still stalled");

  // Refusals and traps on the write side
  AST_USER_WRITE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R7]
    idle_req && is_table_wr && !table_page_reg[TBL_CFG_BIT] |=> o_pm.wr && !o_resp.refused) else $error("user write lost");
  AST_WRITE_TRAP: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R13]
    idle_req && i_req.op == DATA_WRITE_OP && i_req.ea[EA_UPPER_BIT] && write_page_reg == 9'h000
      |=> o_resp.trap && o_resp.done) else $error("missing write trap");

  COV_VIEW_UPPER: cover property (@(posedge i_clk) disable iff (!i_resetn) view_req && read_page_reg[8]);
  COV_TABLE_HIGH: cover property (@(posedge i_clk) disable iff (!i_resetn)
    idle_req && i_req.op == TABLE_READ_HIGH_OP ##2 o_resp.done);
  COV_TRAP: cover property (@(posedge i_clk) disable iff (!i_resetn) o_resp.trap);
  COV_REPEAT_EDGE: cover property (@(posedge i_clk) disable iff (!i_resetn)
    view_req && i_req.in_repeat && i_req.repeat_edge);
  // Refused configuration write must be reached too
  COV_CFG_REFUSED: cover property (@(posedge i_clk) disable iff (!i_resetn) o_resp.refused);

endmodule : program_space_data_access
`default_nettype wire
